// *** rtl/pdmr_pkg.sv ***
package pdmr_pkg;

   localparam int ADDR_W = 12;
   localparam int CHAN_NUM = 16;
   localparam int CHANNEL_INDEX_W = 4;
   localparam int EVT_NUM = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_START = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_STOP = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_SUB_START = 12'h080;
   localparam logic [ADDR_W-1:0] OFS_SUB_STOP = 12'h084;
   localparam logic [ADDR_W-1:0] OFS_EVT_BEGAN = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_EVT_HALTED = 12'h104;
   localparam logic [ADDR_W-1:0] OFS_EVT_DONE = 12'h108;
   localparam logic [ADDR_W-1:0] OFS_PUB_BEGAN = 12'h180;
   localparam logic [ADDR_W-1:0] OFS_PUB_HALTED = 12'h184;
   localparam logic [ADDR_W-1:0] OFS_PUB_DONE = 12'h188;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE = 12'h300;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_SET = 12'h304;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_CLR = 12'h308;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h500;
   localparam logic [ADDR_W-1:0] OFS_CLK_CTRL = 12'h504;
   localparam logic [ADDR_W-1:0] OFS_ROUTING = 12'h508;
   localparam logic [ADDR_W-1:0] OFS_GAIN_L = 12'h518;
   localparam logic [ADDR_W-1:0] OFS_GAIN_R = 12'h51C;
   localparam logic [ADDR_W-1:0] OFS_RATIO = 12'h520;
   localparam logic [ADDR_W-1:0] OFS_PSEL_CLK = 12'h540;
   localparam logic [ADDR_W-1:0] OFS_PSEL_DIN = 12'h544;
   localparam logic [ADDR_W-1:0] OFS_BUF_PTR = 12'h560;
   localparam logic [ADDR_W-1:0] OFS_BUF_CNT = 12'h564;

   // Field positions and masks
   localparam int EN_BIT = 31;
   localparam logic [31:0] LINK_MASK = 32'h8000000F;
   localparam int EVT_BEGAN = 0;
   localparam int EVT_HALTED = 1;
   localparam int EVT_DONE = 2;
   localparam int MONO_BIT = 0;
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] WORD_BYTES = 32'h00000004;
   localparam logic [31:0] SAMPLES_PER_WORD = 32'h00000002;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } pdmr_state_type;

   typedef struct packed {
      pdmr_state_type state;
      logic waitReq;
      logic [31:0] rdata;
      logic [31:0] subStart;
      logic [31:0] subStop;
      logic [EVT_NUM-1:0] flags;
      logic [EVT_NUM-1:0][31:0] pub;
      logic [EVT_NUM-1:0] interrupt_enable;
      logic [31:0] enable;
      logic [31:0] clkCtrl;
      logic [31:0] routing;
      logic [31:0] left_gain;
      logic [31:0] right_gain;
      logic [31:0] ratio;
      logic [31:0] pselClk;
      logic [31:0] pselDin;
      logic [31:0] bufPtr;
      logic [31:0] bufCnt;
      logic [31:0] activePtr;
      logic [31:0] writeAddr;
      logic [31:0] sampCnt;
      logic halfHeld;
      logic [15:0] heldLeft;
      logic stopPend;
      logic memWrite;
      logic [31:0] memAddr;
      logic [31:0] memData;
      logic [CHAN_NUM-1:0] publish;
      logic irq;
   } pdmr_regs_type;

endpackage

// *** rtl/pdmr_regs.sv ***
// Overview of operation
// - Write one to start begins sampling
// - Write one to stop requests halt
// - Enabled start subscription channel triggers start
// - Enabled stop subscription channel triggers stop
// - Began flag set when transfer starts
// - Halted flag set when a stop task ends activity
// - Done flag set on last buffer sample
// - Per-event publication onto chosen channel
// - Interrupt enable, set and clear registers
// - Module enable switches interface on
// - Routing register selects stereo or mono
// - Separate left and right gain registers
// - Clock and data pin select registers
// - Buffer pointer register for sample writes
// - Buffer sample count register
// - Stop waits for current frame end
// - Buffer pointer double-buffered while running
// - After done, continue into next buffer
// - Stereo packs R high, L low; mono two lefts
`timescale 1ns/1ps
`default_nettype none
module pdmr_regs (
   input wire logic mclk, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [pdmr_pkg::ADDR_W-1:0] address, // Avalon byte address
   input wire logic read, // Avalon read request
   input wire logic write, // Avalon write request
   input wire logic [31:0] writedata, // Avalon write data
   input wire logic [3:0] byteenable, // Avalon byte lanes
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon wait request
   input wire logic [pdmr_pkg::CHAN_NUM-1:0] chanEvents, // Interconnect channel pulses
   output logic [pdmr_pkg::CHAN_NUM-1:0] chanPublish, // Published event pulses
   input wire logic sampleStrobe, // Filter output sample pair valid
   input wire logic [15:0] leftSample, // Left filtered sample
   input wire logic [15:0] rightSample, // Right filtered sample
   output logic memWrite, // Sample word write strobe
   output logic [31:0] memAddr, // Sample word byte address
   output logic [31:0] memData, // Packed sample word
   output logic running, // Transfer active
   output logic moduleEnabled, // Module enable bit
   output logic irq // Pending enabled event
);
   import pdmr_pkg::*;

   pdmr_regs_type r_reg;
   pdmr_regs_type r_next;
   logic wAcc;
   logic startTask;
   logic stopTask;
   logic stopNow;
   logic wordDone;
   logic [31:0] wordData;
   logic [EVT_NUM-1:0] evt;
   logic [31:0] mask;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   always_comb begin
      r_next = r_reg;
      mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
      wAcc = write & ~r_reg.waitReq;
      evt = '0;
      wordDone = 1'b0;
      wordData = RST_ZERO;
      stopNow = 1'b0;

      // One wait cycle per request, then a single ready cycle
      r_next.waitReq = ~((read | write) & r_reg.waitReq);

      // Read data latched in the wait cycle, stands at the ready edge
      unique case (address)
         OFS_SUB_START: r_next.rdata = r_reg.subStart;
         OFS_SUB_STOP: r_next.rdata = r_reg.subStop;
         OFS_EVT_BEGAN: r_next.rdata = {31'h00000000, r_reg.flags[EVT_BEGAN]};
         OFS_EVT_HALTED: r_next.rdata = {31'h00000000, r_reg.flags[EVT_HALTED]};
         OFS_EVT_DONE: r_next.rdata = {31'h00000000, r_reg.flags[EVT_DONE]};
         OFS_PUB_BEGAN: r_next.rdata = r_reg.pub[EVT_BEGAN];
         OFS_PUB_HALTED: r_next.rdata = r_reg.pub[EVT_HALTED];
         OFS_PUB_DONE: r_next.rdata = r_reg.pub[EVT_DONE];
         OFS_INTERRUPT_ENABLE, OFS_INTERRUPT_ENABLE_SET, OFS_INTERRUPT_ENABLE_CLR: r_next.rdata = {29'h00000000, r_reg.interrupt_enable};
         OFS_ENABLE: r_next.rdata = r_reg.enable;
         OFS_CLK_CTRL: r_next.rdata = r_reg.clkCtrl;
         OFS_ROUTING: r_next.rdata = r_reg.routing;
         OFS_GAIN_L: r_next.rdata = r_reg.left_gain;
         OFS_GAIN_R: r_next.rdata = r_reg.right_gain;
         OFS_RATIO: r_next.rdata = r_reg.ratio;
         OFS_PSEL_CLK: r_next.rdata = r_reg.pselClk;
         OFS_PSEL_DIN: r_next.rdata = r_reg.pselDin;
         OFS_BUF_PTR: r_next.rdata = r_reg.bufPtr;
         OFS_BUF_CNT: r_next.rdata = r_reg.bufCnt;
         default: r_next.rdata = RST_ZERO;
      endcase

      // Configuration writes; task registers read as zero
      if (wAcc) begin
         unique case (address)
            OFS_SUB_START: r_next.subStart = merge(r_reg.subStart, writedata, mask) & LINK_MASK;
            OFS_SUB_STOP: r_next.subStop = merge(r_reg.subStop, writedata, mask) & LINK_MASK;
            OFS_PUB_BEGAN: r_next.pub[EVT_BEGAN] = merge(r_reg.pub[EVT_BEGAN], writedata, mask) & LINK_MASK;
            OFS_PUB_HALTED: r_next.pub[EVT_HALTED] = merge(r_reg.pub[EVT_HALTED], writedata, mask) & LINK_MASK;
            OFS_PUB_DONE: r_next.pub[EVT_DONE] = merge(r_reg.pub[EVT_DONE], writedata, mask) & LINK_MASK;
            OFS_INTERRUPT_ENABLE: if (byteenable[0]) r_next.interrupt_enable = writedata[EVT_NUM-1:0];
            OFS_INTERRUPT_ENABLE_SET: if (byteenable[0]) r_next.interrupt_enable = r_reg.interrupt_enable | writedata[EVT_NUM-1:0];
            OFS_INTERRUPT_ENABLE_CLR: if (byteenable[0]) r_next.interrupt_enable = r_reg.interrupt_enable & ~writedata[EVT_NUM-1:0];
            OFS_ENABLE: r_next.enable = merge(r_reg.enable, writedata, mask);
            OFS_CLK_CTRL: r_next.clkCtrl = merge(r_reg.clkCtrl, writedata, mask);
            OFS_ROUTING: r_next.routing = merge(r_reg.routing, writedata, mask);
            OFS_GAIN_L: r_next.left_gain = merge(r_reg.left_gain, writedata, mask);
            OFS_GAIN_R: r_next.right_gain = merge(r_reg.right_gain, writedata, mask);
            OFS_RATIO: r_next.ratio = merge(r_reg.ratio, writedata, mask);
            OFS_PSEL_CLK: r_next.pselClk = merge(r_reg.pselClk, writedata, mask);
            OFS_PSEL_DIN: r_next.pselDin = merge(r_reg.pselDin, writedata, mask);
            OFS_BUF_PTR: r_next.bufPtr = merge(r_reg.bufPtr, writedata, mask);
            OFS_BUF_CNT: r_next.bufCnt = merge(r_reg.bufCnt, writedata, mask);
            default: r_next.enable = r_reg.enable;
         endcase
      end

      // Tasks from the bus or from a subscribed channel
      startTask = (wAcc & (address == OFS_START) & byteenable[0] & writedata[0])
         | (r_reg.subStart[EN_BIT] & chanEvents[r_reg.subStart[CHANNEL_INDEX_W-1:0]]);
      stopTask = (wAcc & (address == OFS_STOP) & byteenable[0] & writedata[0])
         | (r_reg.subStop[EN_BIT] & chanEvents[r_reg.subStop[CHANNEL_INDEX_W-1:0]]);

      // Sample packing
      if (r_reg.routing[MONO_BIT]) begin
         wordDone = sampleStrobe & r_reg.halfHeld;
         wordData = {leftSample, r_reg.heldLeft};
      end else begin
         wordDone = sampleStrobe;
         wordData = {rightSample, leftSample};
      end

      r_next.memWrite = 1'b0;
      unique case (r_reg.state)
         ST_IDLE: begin
            if (startTask & r_reg.enable[0]) begin
               r_next.state = ST_RUN;
               r_next.activePtr = r_reg.bufPtr;
               r_next.writeAddr = r_reg.bufPtr;
               r_next.sampCnt = RST_ZERO;
               r_next.halfHeld = 1'b0;
               r_next.stopPend = 1'b0;
               evt[EVT_BEGAN] = 1'b1;
            end else if (stopTask) begin
               evt[EVT_HALTED] = 1'b1;
            end
         end
         ST_RUN: begin
            stopNow = r_reg.stopPend | stopTask;
            if (stopTask) begin
               r_next.stopPend = 1'b1;
            end
            if (!r_reg.enable[0]) begin
               r_next.state = ST_IDLE;
            end else if (sampleStrobe & !wordDone) begin
               r_next.heldLeft = leftSample;
               r_next.halfHeld = 1'b1;
            end else if (wordDone) begin
               r_next.halfHeld = 1'b0;
               r_next.memWrite = 1'b1;
               r_next.memAddr = r_reg.writeAddr;
               r_next.memData = wordData;
               r_next.writeAddr = r_reg.writeAddr + WORD_BYTES;
               r_next.sampCnt = r_reg.sampCnt + SAMPLES_PER_WORD;
               if (stopNow) begin
                  evt[EVT_DONE] = 1'b1;
                  evt[EVT_HALTED] = 1'b1;
                  r_next.state = ST_IDLE;
               end else if (r_reg.sampCnt + SAMPLES_PER_WORD >= r_reg.bufCnt) begin
                  evt[EVT_DONE] = 1'b1;
                  evt[EVT_BEGAN] = 1'b1;
                  r_next.activePtr = r_reg.bufPtr;
                  r_next.writeAddr = r_reg.bufPtr;
                  r_next.sampCnt = RST_ZERO;
               end
            end
         end
      endcase

      // Sticky flags: hardware set wins over a software clear
      for (int i = 0; i < EVT_NUM; i++) begin
         if (wAcc & byteenable[0] & (address == OFS_EVT_BEGAN + ADDR_W'(4 * i))) begin
            r_next.flags[i] = writedata[0];
         end
         if (evt[i]) begin
            r_next.flags[i] = 1'b1;
         end
      end

      r_next.publish = '0;
      for (int i = 0; i < EVT_NUM; i++) begin
         if (evt[i] & r_reg.pub[i][EN_BIT]) begin
            r_next.publish[r_reg.pub[i][CHANNEL_INDEX_W-1:0]] = 1'b1;
         end
      end

      r_next.irq = |(r_reg.flags & r_reg.interrupt_enable);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.waitReq <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign readdata = r_reg.rdata;
   assign waitrequest = r_reg.waitReq;
   assign chanPublish = r_reg.publish;
   assign memWrite = r_reg.memWrite;
   assign memAddr = r_reg.memAddr;
   assign memData = r_reg.memData;
   assign running = r_reg.state == ST_RUN;
   assign moduleEnabled = r_reg.enable[0];
   assign irq = r_reg.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   startTask_a: assert property ((r_reg.state == ST_IDLE) && r_reg.enable[0] && startTask
      |=> (r_reg.state == ST_RUN) && r_reg.flags[EVT_BEGAN] && (r_reg.writeAddr == $past(r_reg.bufPtr)))
      else $error("start task did not begin transfer");

   stopPend_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && stopTask && !wordDone
      |=> r_reg.stopPend)
      else $error("stop request not held");

   subStart_a: assert property ((r_reg.state == ST_IDLE) && r_reg.enable[0] && r_reg.subStart[EN_BIT]
      && chanEvents[r_reg.subStart[CHANNEL_INDEX_W-1:0]] |=> r_reg.state == ST_RUN)
      else $error("subscribed start ignored");

   subStop_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && r_reg.subStop[EN_BIT]
      && chanEvents[r_reg.subStop[CHANNEL_INDEX_W-1:0]] && !wordDone |=> r_reg.stopPend)
      else $error("subscribed stop ignored");

   beganFlag_a: assert property ($rose(r_reg.flags[EVT_BEGAN]) |-> $past(evt[EVT_BEGAN])
      || $past(wAcc && (address == OFS_EVT_BEGAN) && byteenable[0] && writedata[0]))
      else $error("began flag set without event");

   haltIdle_a: assert property (evt[EVT_HALTED] |=> (r_reg.state == ST_IDLE) && r_reg.flags[EVT_HALTED])
      else $error("halted event while still running");

   doneCount_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && !stopNow
      && (r_reg.sampCnt + SAMPLES_PER_WORD >= r_reg.bufCnt) |=> r_reg.flags[EVT_DONE] && (r_reg.sampCnt == 0))
      else $error("buffer done not raised at count");

   publish_a: assert property (evt[EVT_DONE] && r_reg.pub[EVT_DONE][EN_BIT]
      |=> chanPublish[$past(r_reg.pub[EVT_DONE][CHANNEL_INDEX_W-1:0])])
      else $error("done event not published");

   interrupt_enable_set_a: assert property (wAcc && (address == OFS_INTERRUPT_ENABLE_SET) && byteenable[0]
      |=> (r_reg.interrupt_enable & $past(writedata[EVT_NUM-1:0])) == $past(writedata[EVT_NUM-1:0]))
      else $error("interrupt enable set failed");

   stereoPack_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && sampleStrobe
      && !r_reg.routing[MONO_BIT] |=> memWrite && (memData == {$past(rightSample), $past(leftSample)}))
      else $error("stereo word packed wrongly");

   ptrHold_a: assert property ((r_reg.state == ST_RUN) && !evt[EVT_DONE] |=> $stable(r_reg.activePtr))
      else $error("active pointer disturbed mid buffer");

   irqLevel_a: assert property (##1 irq == |($past(r_reg.flags) & $past(r_reg.interrupt_enable)))
      else $error("interrupt does not follow flags");

   startBus_a: assert property ((r_reg.state == ST_IDLE) && r_reg.enable[0] && (address == OFS_START)
      && wAcc && byteenable[0] && writedata[0] |=> running)
      else $error("start write did not run");

   startRead_a: assert property (read && (address == OFS_START) |=> (readdata == RST_ZERO))
      else $error("start register not read as zero");

   stopRead_a: assert property (read && (address == OFS_STOP) |=> (readdata == RST_ZERO))
      else $error("stop register not read as zero");

   subOff_a: assert property ((r_reg.state == ST_IDLE) && !r_reg.subStart[EN_BIT]
      && !(wAcc && (address == OFS_START)) |=> (r_reg.state == ST_IDLE))
      else $error("start without a trigger");

   haltRise_a: assert property ($rose(r_reg.flags[EVT_HALTED]) && !$past(wAcc)
      |-> (r_reg.state == ST_IDLE))
      else $error("halted raised while running");

   doneStop_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && stopNow
      |=> r_reg.flags[EVT_DONE] && r_reg.flags[EVT_HALTED] && (r_reg.state == ST_IDLE))
      else $error("stopped word did not end transfer");

   pubBegan_a: assert property (evt[EVT_BEGAN] && r_reg.pub[EVT_BEGAN][EN_BIT]
      |=> chanPublish[$past(r_reg.pub[EVT_BEGAN][CHANNEL_INDEX_W-1:0])])
      else $error("began event not published");

   pubQuiet_a: assert property ((evt == '0) |=> (chanPublish == '0))
      else $error("publish without event");

   interrupt_enable_clear_a: assert property (wAcc && (address == OFS_INTERRUPT_ENABLE_CLR) && byteenable[0]
      |=> ((r_reg.interrupt_enable & $past(writedata[EVT_NUM-1:0])) == '0))
      else $error("interrupt enable clear failed");

   intenWrite_a: assert property (wAcc && (address == OFS_INTERRUPT_ENABLE) && byteenable[0]
      |=> (r_reg.interrupt_enable == $past(writedata[EVT_NUM-1:0])))
      else $error("interrupt enable write failed");

   enableGate_a: assert property ((r_reg.state == ST_IDLE) && !r_reg.enable[0]
      |=> (r_reg.state == ST_IDLE))
      else $error("disabled module started");

   monoHalf_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && r_reg.routing[MONO_BIT]
      && sampleStrobe && !r_reg.halfHeld |=> !memWrite && r_reg.halfHeld)
      else $error("mono first half not held");

   monoPack_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && r_reg.routing[MONO_BIT]
      && sampleStrobe && r_reg.halfHeld |=> memWrite && (memData == {$past(leftSample), $past(r_reg.heldLeft)}))
      else $error("mono word packed wrongly");

   gainLeft_a: assert property (wAcc && (address == OFS_GAIN_L) && (byteenable == 4'hF)
      |=> (r_reg.left_gain == $past(writedata)))
      else $error("left gain not stored");

   gainRead_a: assert property (read && (address == OFS_GAIN_R) |=> (readdata == $past(r_reg.right_gain)))
      else $error("right gain read wrongly");

   pinClk_a: assert property (wAcc && (address == OFS_PSEL_CLK) && (byteenable == 4'hF)
      |=> (r_reg.pselClk == $past(writedata)))
      else $error("clock pin select not stored");

   addrOut_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone
      |=> memWrite && (memAddr == $past(r_reg.writeAddr)))
      else $error("word written to wrong address");

   addrStep_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && !stopNow
      && (r_reg.sampCnt + SAMPLES_PER_WORD < r_reg.bufCnt) |=> (r_reg.writeAddr == $past(r_reg.writeAddr) + WORD_BYTES))
      else $error("write address did not advance");

   cntStep_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && !stopNow
      && (r_reg.sampCnt + SAMPLES_PER_WORD < r_reg.bufCnt) |=> (r_reg.sampCnt == $past(r_reg.sampCnt) + SAMPLES_PER_WORD))
      else $error("sample count did not advance");

   stopWait_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && stopTask && !wordDone
      |=> (r_reg.state == ST_RUN))
      else $error("stop cut the current frame");

   reloadPtr_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && !stopNow
      && (r_reg.sampCnt + SAMPLES_PER_WORD >= r_reg.bufCnt) |=> (r_reg.writeAddr == $past(r_reg.bufPtr)))
      else $error("next buffer pointer not taken");

   doneRestart_a: assert property ((r_reg.state == ST_RUN) && r_reg.enable[0] && wordDone && !stopNow
      && (r_reg.sampCnt + SAMPLES_PER_WORD >= r_reg.bufCnt) |=> running && r_reg.flags[EVT_BEGAN])
      else $error("transfer did not continue");

   flagHold_a: assert property (r_reg.flags[EVT_DONE] && !(wAcc && (address == OFS_EVT_DONE))
      |=> r_reg.flags[EVT_DONE])
      else $error("done flag lost");

   flagClear_a: assert property (wAcc && (address == OFS_EVT_DONE) && byteenable[0] && !writedata[0]
      && !evt[EVT_DONE] |=> !r_reg.flags[EVT_DONE])
      else $error("done flag not cleared");

endmodule
`default_nettype wire

// *** testbench/pdmr_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdmr_far_model (
   input wire logic mclk, // System clock
   output logic [pdmr_pkg::CHAN_NUM-1:0] chanEvents, // Channel pulses
   output logic sampleStrobe, // Sample pair valid
   output logic [15:0] leftSample, // Left sample
   output logic [15:0] rightSample // Right sample
);
   import pdmr_pkg::*;
   initial begin
      chanEvents = '0;
      sampleStrobe = 1'b0;
      leftSample = 16'h0000;
      rightSample = 16'h0000;
   end
   task automatic pulse(input int ch);
      @(posedge mclk);
      chanEvents <= CHAN_NUM'(1) << ch;
      @(posedge mclk);
      chanEvents <= '0;
   endtask
   task automatic send(input logic [15:0] l, input logic [15:0] r);
      @(posedge mclk);
      sampleStrobe <= 1'b1;
      leftSample <= l;
      rightSample <= r;
      @(posedge mclk);
      // Released data lines carry no stale value
      sampleStrobe <= 1'b0;
      leftSample <= ~l;
      rightSample <= ~r;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pdmr_pkg::*;
   localparam logic [11:0] CFG [8] = '{OFS_RATIO, OFS_CLK_CTRL, OFS_GAIN_L, OFS_GAIN_R,
      OFS_PSEL_CLK, OFS_PSEL_DIN, OFS_BUF_PTR, OFS_BUF_CNT};
   localparam logic [11:0] OTH [10] = '{OFS_SUB_START, OFS_SUB_STOP, OFS_EVT_BEGAN, OFS_EVT_HALTED,
      OFS_EVT_DONE, OFS_PUB_BEGAN, OFS_PUB_HALTED, OFS_PUB_DONE, OFS_INTERRUPT_ENABLE, OFS_ROUTING};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = '0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata, memAddr, memData, q, p1, p2;
   logic waitrequest, memWrite, running, moduleEnabled, irq, sampleStrobe;
   logic [CHAN_NUM-1:0] chanEvents, chanPublish;
   logic [CHAN_NUM-1:0] pubSeen = '0;
   logic [15:0] leftSample, rightSample;
   logic [63:0] expQ [$];
   int mismatches = 0;
   int comparisons = 0;
   always #2.5 mclk = ~mclk;
   pdmr_regs u_pdmr_regs (.mclk(mclk), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .chanEvents(chanEvents), .chanPublish(chanPublish),
      .sampleStrobe(sampleStrobe), .leftSample(leftSample), .rightSample(rightSample),
      .memWrite(memWrite), .memAddr(memAddr), .memData(memData), .running(running),
      .moduleEnabled(moduleEnabled), .irq(irq));
   pdmr_far_model u_pdmr_far_model (.mclk(mclk), .chanEvents(chanEvents),
      .sampleStrobe(sampleStrobe), .leftSample(leftSample), .rightSample(rightSample));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         test_done();
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(q, e);
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk);
   endtask
   // Stereo word: right in the upper half, left in the lower
   task automatic st(input logic [31:0] a);
      logic [15:0] l, r;
      l = 16'($urandom);
      r = 16'($urandom);
      expQ.push_back({a, r, l});
      u_pdmr_far_model.send(l, r);
   endtask
   task automatic mo(input logic [31:0] a);
      logic [15:0] l1, l2;
      l1 = 16'($urandom);
      l2 = 16'($urandom);
      expQ.push_back({a, l2, l1});
      u_pdmr_far_model.send(l1, 16'h0000);
      u_pdmr_far_model.send(l2, 16'h0000);
   endtask
   always @(posedge mclk) begin
      pubSeen <= pubSeen | chanPublish;
      if (memWrite === 1'b1) begin
         if (expQ.size() == 0) begin
            chk(32'h00000001, 32'h00000000);
         end else begin
            chk(memAddr, expQ[0][63:32]);
            chk(memData, expQ[0][31:0]);
            void'(expQ.pop_front());
         end
      end
   end
   initial begin
      void'($urandom(32'hD5731EE2));
      repeat (4) @(posedge mclk);
      chk({31'h0, waitrequest}, 32'h00000001);
      resetn <= 1'b1;
      foreach (OTH[i]) rd(OTH[i], RST_ZERO);
      foreach (CFG[i]) begin
         rd(CFG[i], RST_ZERO);
         p1 = $urandom;
         wr(CFG[i], p1);
         rd(CFG[i], p1);
      end
      wr(OFS_SUB_STOP, 32'hFFFFFFFF);
      rd(OFS_SUB_STOP, LINK_MASK);
      wr(12'h010, $urandom);
      rd(12'h010, RST_ZERO);
      rd(12'h102, RST_ZERO);
      wr(OFS_INTERRUPT_ENABLE, 32'h00000002);
      wr(OFS_INTERRUPT_ENABLE_SET, 32'h00000005);
      rd(OFS_INTERRUPT_ENABLE, 32'h00000007);
      wr(OFS_INTERRUPT_ENABLE_CLR, 32'h00000006);
      rd(OFS_INTERRUPT_ENABLE_SET, 32'h00000001);
      wr(OFS_ENABLE, 32'h00000001);
      settle();
      chk({31'h0, moduleEnabled}, 32'h00000001);
      wr(OFS_ROUTING, 32'h00000000);
      p1 = $urandom & 32'hFFFFFFFC;
      wr(OFS_BUF_PTR, p1);
      wr(OFS_BUF_CNT, 32'h00000004);
      wr(OFS_PUB_BEGAN, 32'h80000005);
      wr(OFS_PUB_DONE, 32'h8000000C);
      wr(OFS_SUB_START, 32'h80000003);
      wr(OFS_SUB_STOP, 32'h80000009);
      u_pdmr_far_model.pulse(4);
      settle();
      chk({31'h0, running}, 32'h00000000);
      u_pdmr_far_model.pulse(3);
      settle();
      chk({31'h0, running}, 32'h00000001);
      rd(OFS_EVT_BEGAN, 32'h00000001);
      chk({16'h0, pubSeen}, 32'h00000020);
      chk({31'h0, irq}, 32'h00000001);
      wr(OFS_EVT_BEGAN, 32'h00000000);
      rd(OFS_EVT_BEGAN, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
      p2 = $urandom & 32'hFFFFFFFC;
      wr(OFS_BUF_PTR, p2);
      st(p1);
      st(p1 + 32'h4);
      st(p2);
      rd(OFS_EVT_DONE, 32'h00000001);
      chk({16'h0, pubSeen}, 32'h00001020);
      rd(OFS_EVT_BEGAN, 32'h00000001);
      rd(OFS_EVT_HALTED, 32'h00000000);
      u_pdmr_far_model.pulse(9);
      settle();
      chk({31'h0, running}, 32'h00000001);
      st(p2 + 32'h4);
      settle();
      chk({31'h0, running}, 32'h00000000);
      rd(OFS_EVT_HALTED, 32'h00000001);
      wr(OFS_SUB_START, 32'h00000000);
      wr(OFS_ROUTING, 32'h00000001);
      wr(OFS_EVT_HALTED, 32'h00000000);
      wr(OFS_EVT_DONE, 32'h00000000);
      p1 = $urandom & 32'hFFFFFFFC;
      wr(OFS_BUF_PTR, p1);
      wr(OFS_BUF_CNT, 32'h00000008);
      u_pdmr_far_model.pulse(3);
      settle();
      chk({31'h0, running}, 32'h00000000);
      wr(OFS_START, 32'h00000001);
      settle();
      chk({31'h0, running}, 32'h00000001);
      rd(OFS_START, RST_ZERO);
      mo(p1);
      wr(OFS_STOP, 32'h00000001);
      rd(OFS_STOP, RST_ZERO);
      mo(p1 + 32'h4);
      settle();
      chk({31'h0, running}, 32'h00000000);
      rd(OFS_EVT_HALTED, 32'h00000001);
      rd(OFS_EVT_DONE, 32'h00000001);
      wr(OFS_ENABLE, 32'h00000000);
      wr(OFS_START, 32'h00000001);
      settle();
      chk({31'h0, running}, 32'h00000000);
      chk(32'(expQ.size()), 32'h00000000);
      test_done();
   end
endmodule
`default_nettype wire
